// >>> shared/fdc_aux_consts.vh
// Purpose: constants of the auxiliary command decoder
// Assumes: included by bare name from the rtl files
// Notes: definitions only
`ifndef FDC_AUX_CONSTS_VH
`define FDC_AUX_CONSTS_VH

////////////////////////////////////////////////////////////////////////
// Register offsets
`define OFS_DATA 2'h0
`define OFS_MSR 2'h1
`define OFS_IRQ_STAT 2'h2
`define OFS_IRQ_MASK 2'h3

////////////////////////////////////////////////////////////////////////
// Opcode matching: (byte & mask) == value
`define OP_SENSE 8'h04
`define OP_SEEK 8'h0F
`define OP_CONFIG 8'h13
`define OP_DUMP 8'h0E
`define OP_PERP 8'h12
`define MASK_MFM 8'hBF
`define OP_READ_ID 8'h0A
`define OP_REL_SEEK 8'h8F
`define MASK_LOCK 8'h7F
`define OP_LOCK 8'h14

// Internal command codes
`define CMD_SENSE 4'h0
`define CMD_SEEK 4'h1
`define CMD_CONFIG 4'h2
`define CMD_REL_SEEK 4'h3
`define CMD_DUMP 4'h4
`define CMD_READ_ID 4'h5
`define CMD_PERP 4'h6
`define CMD_LOCK 4'h7
`define CMD_INVALID 4'h8

////////////////////////////////////////////////////////////////////////
// Field positions
`define BIT_MFM 6
`define BIT_DIR 6
`define BIT_LOCK 7
`define BIT_OVERWRITE 7
`define BIT_EIS 6
`define BIT_BUF_OFF 5
`define BIT_POLL 4
`define IRQ_SEEK_DONE 0
`define IRQ_RESULT 1
`define IRQ_INVALID 2

////////////////////////////////////////////////////////////////////////
// Reset values
`define RST_INVALID_ST0 8'h80
`define RST_STEP_HUT 8'hF0
`define RST_HLT_ND 8'h02
`define RST_CONFIG 8'h20
`define RST_PRECOMP_START_CYLINDER 8'h00

////////////////////////////////////////////////////////////////////////
// Timing
`define CLK_PERIOD_NS 8
`define STEP_TIME_NS 3000
`define STEP_CYC ((`STEP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> rtl/pin_sync.v
// Purpose: three-stage synchroniser for drive status pins
// Assumes: pins are asynchronous to core_clk
// Notes: output moves only when stages two and three agree
module pin_sync #(
  parameter W = 3
) (
  input wire core_clk,
  input wire nrst,
  input wire ce,
  input wire [W-1:0] pinIn,
  output wire [W-1:0] pinOut
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg s1_r;
      reg s2_r;
      reg s3_r;
      reg q_r;
      always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
          q_r <= 1'b0;
        end else if (ce) begin
          s1_r <= pinIn[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
          // Filters a single-cycle glitch past the metastable stage
          if (s2_r == s3_r) begin
            q_r <= s3_r;
          end
        end
      end
      assign pinOut[i] = q_r;
    end
  endgenerate

endmodule

// >>> rtl/head_stepper.v
// Purpose: emits a counted train of head step pulses
// Assumes: start is a one-cycle pulse while idle
// Notes: fixed step spacing, done comes one step spacing after the last step
`include "fdc_aux_consts.vh"
module head_stepper (
  input wire core_clk,
  input wire nrst,
  input wire ce,
  input wire start,
  input wire dirIn,
  input wire [7:0] count,
  output reg stepPulse,
  output reg stepDir,
  output reg busy,
  output reg done
);

  localparam integer STEP_LOAD_I = `STEP_CYC - 1;
  localparam [15:0] STEP_LOAD = STEP_LOAD_I[15:0];

  reg [7:0] remain_r;
  reg [15:0] timer_r;

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stepPulse <= 1'b0;
      stepDir <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      remain_r <= 8'h00;
      timer_r <= 16'h0000;
    end else if (ce) begin
      stepPulse <= 1'b0;
      done <= 1'b0;
      if (start && !busy) begin
        remain_r <= count;
        stepDir <= dirIn;
        timer_r <= 16'h0000;
        busy <= 1'b1;
      end else if (busy) begin
        if (timer_r != 16'h0000) begin
          timer_r <= timer_r - 16'h0001;
        end else if (remain_r == 8'h00) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          stepPulse <= 1'b1;
          remain_r <= remain_r - 8'h01;
          timer_r <= STEP_LOAD;
        end
      end
    end
  end

endmodule

// >>> rtl/floppy_aux_command_decoder.v
// Purpose: command, execution and result phases of auxiliary commands
// Assumes: host strobes are single-cycle, same clock domain
// Notes: data transfers themselves live outside, see xfer ports
//
// Behaviour
// R1: Sense drive: opcode 04, one byte, state result
// R2: Seek: opcode 0F, drive byte, target cylinder
// R3: Read ID: bit 6 density, capture first ID
// R4: Read ID result starts with three status bytes
// R5: Then cylinder, head, sector, size in order
// R6: Unknown opcode: standby, single result 80H
// R7: Dump shows sector count after a format
// R8: Dump shows final sector after read/write
// R9: Unit selects stay internal, never on pins
// R10: Host keeps unit selects matching output register
// R11: Relative seek: bit 6 direction, step count
// R12: Lock: bit 7 stored, result bit 4
// R13: Implied seek precedes transfer when enabled
// R14: Drive busy shown while its seek runs
`include "fdc_aux_consts.vh"
module floppy_aux_command_decoder (
  input wire core_clk,
  input wire nrst,
  input wire ce,
  input wire [1:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  output wire irq,
  input wire writeProtPin,
  input wire readyPin,
  input wire track0Pin,
  input wire idFound,
  input wire [7:0] idCyl,
  input wire [7:0] idHead,
  input wire [7:0] idSector,
  input wire [7:0] idSize,
  output wire idReadEn,
  output reg mfmSel,
  output reg headSide,
  output wire stepPulse,
  output wire stepDir,
  output reg standby,
  input wire xferStart,
  input wire xferIsFormat,
  input wire [1:0] xferUnit,
  input wire [7:0] xferCyl,
  input wire [7:0] xferSc,
  input wire [7:0] xferEot,
  output wire xferReady,
  output reg xferGo
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_PARAM = 3'h1;
  localparam [2:0] ST_EXEC = 3'h2;
  localparam [2:0] ST_SEEK = 3'h3;
  localparam [2:0] ST_IDWAIT = 3'h4;
  localparam [2:0] ST_RESULT = 3'h5;
  localparam [7:0] CFG_RST = `RST_CONFIG;

  ////////////////////////////////////////////////////////////////////////
  // Opcode decode
  function [3:0] cmdOf;
    input [7:0] b;
    begin
      if (b == `OP_SENSE) cmdOf = `CMD_SENSE; // R1
      else if (b == `OP_SEEK) cmdOf = `CMD_SEEK; // R2
      else if (b == `OP_CONFIG) cmdOf = `CMD_CONFIG;
      else if (b == `OP_DUMP) cmdOf = `CMD_DUMP;
      else if (b == `OP_PERP) cmdOf = `CMD_PERP;
      else if ((b & `MASK_MFM) == `OP_READ_ID) cmdOf = `CMD_READ_ID; // R3
      else if ((b & `MASK_MFM) == `OP_REL_SEEK) cmdOf = `CMD_REL_SEEK; // R11
      else if ((b & `MASK_LOCK) == `OP_LOCK) cmdOf = `CMD_LOCK; // R12
      else cmdOf = `CMD_INVALID; // R6
    end
  endfunction

  function [1:0] paramsOf;
    input [3:0] c;
    begin
      case (c)
        `CMD_SENSE, `CMD_READ_ID, `CMD_PERP: paramsOf = 2'd1;
        `CMD_SEEK, `CMD_REL_SEEK: paramsOf = 2'd2;
        `CMD_CONFIG: paramsOf = 2'd3;
        default: paramsOf = 2'd0;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State
  reg [2:0] state_r;
  reg [7:0] opcode_r;
  reg [3:0] cmd_r;
  reg [1:0] parIdx_r;
  reg [7:0] par_r [0:2];
  reg [7:0] resBuf_r [0:9];
  reg [3:0] resCnt_r;
  reg [3:0] resIdx_r;
  reg [7:0] pcn_r [0:3];
  reg [1:0] seekUnit_r;
  reg [7:0] seekTarget_r;
  reg seekStart_r;
  reg seekDirIn_r;
  reg [7:0] seekCount_r;
  reg implied_r;
  reg eis_r;
  reg bufOff_r;
  reg poll_r;
  reg [3:0] thr_r;
  reg [7:0] precomp_start_cylinder_r;
  reg lock_r;
  reg [5:0] perp_r;
  reg [7:0] shared_r;
  reg [2:0] irqSt_r;
  reg [2:0] mask_r;
  reg [2:0] irqSet;
  reg [2:0] irqClr;

  wire [2:0] pins;
  wire stepBusy;
  wire stepDone;
  wire wrData = wr && (addr == `OFS_DATA);
  wire rdData = rd && (addr == `OFS_DATA);
  wire [3:0] newCmd = cmdOf(wdata);
  wire [1:0] newPars = paramsOf(newCmd);
  wire [1:0] unitSel = par_r[0][1:0];
  wire [7:0] curPcn = pcn_r[unitSel];
  // Direction rides in the opcode, count is the second byte
  wire [7:0] relTarget = opcode_r[`BIT_DIR] ? curPcn + par_r[1]
                         : curPcn - par_r[1];
  wire [3:0] driveBusy;
  wire [7:0] mainStatus;
  wire [7:0] driveState;

  assign driveState = {1'b0, pins[2], pins[1], pins[0], 1'b1,
                       par_r[0][2:0]};
  // Busy for the seeking unit only
  assign driveBusy = (state_r == ST_SEEK) ?
                     (4'h1 << seekUnit_r) : 4'h0; // R14
  assign mainStatus = {(state_r == ST_IDLE) || (state_r == ST_PARAM) ||
                       (state_r == ST_RESULT),
                       state_r == ST_RESULT, 1'b0,
                       state_r != ST_IDLE, driveBusy};
  assign idReadEn = (state_r == ST_IDWAIT);
  assign xferReady = (state_r == ST_IDLE);
  assign irq = |(irqSt_r & mask_r);

  pin_sync #(
    .W(3)
  ) u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .ce(ce),
    .pinIn({writeProtPin, readyPin, track0Pin}),
    .pinOut(pins)
  );

  head_stepper u_step (
    .core_clk(core_clk),
    .nrst(nrst),
    .ce(ce),
    .start(seekStart_r),
    .dirIn(seekDirIn_r),
    .count(seekCount_r),
    .stepPulse(stepPulse),
    .stepDir(stepDir),
    .busy(stepBusy),
    .done(stepDone)
  );

  ////////////////////////////////////////////////////////////////////////
  // Interrupt events
  always @* begin
    irqSet = 3'h0;
    irqSet[`IRQ_SEEK_DONE] = (state_r == ST_SEEK) && stepDone && !implied_r;
    irqSet[`IRQ_INVALID] = (state_r == ST_EXEC) && (cmd_r == `CMD_INVALID);
    irqSet[`IRQ_RESULT] = ((state_r == ST_EXEC) &&
                           ((cmd_r == `CMD_SENSE) || (cmd_r == `CMD_DUMP) ||
                            (cmd_r == `CMD_LOCK) ||
                            (cmd_r == `CMD_INVALID))) ||
                          ((state_r == ST_IDWAIT) && idFound);
    irqClr = (wr && (addr == `OFS_IRQ_STAT)) ? wdata[2:0] : 3'h0;
  end

  integer k;

  ////////////////////////////////////////////////////////////////////////
  // Command sequencer and register port
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      opcode_r <= 8'h00;
      cmd_r <= `CMD_SENSE;
      parIdx_r <= 2'd0;
      resCnt_r <= 4'h0;
      resIdx_r <= 4'h0;
      seekUnit_r <= 2'h0;
      seekTarget_r <= 8'h00;
      seekStart_r <= 1'b0;
      seekDirIn_r <= 1'b0;
      seekCount_r <= 8'h00;
      implied_r <= 1'b0;
      eis_r <= CFG_RST[`BIT_EIS];
      bufOff_r <= CFG_RST[`BIT_BUF_OFF];
      poll_r <= CFG_RST[`BIT_POLL];
      thr_r <= CFG_RST[3:0];
      precomp_start_cylinder_r <= `RST_PRECOMP_START_CYLINDER;
      lock_r <= 1'b0;
      perp_r <= 6'h00;
      shared_r <= 8'h00;
      irqSt_r <= 3'h0;
      mask_r <= 3'h0;
      rdata <= 8'h00;
      mfmSel <= 1'b0;
      headSide <= 1'b0;
      standby <= 1'b0;
      xferGo <= 1'b0;
      for (k = 0; k < 3; k = k + 1) par_r[k] <= 8'h00;
      for (k = 0; k < 10; k = k + 1) resBuf_r[k] <= 8'h00;
      for (k = 0; k < 4; k = k + 1) pcn_r[k] <= 8'h00;
    end else if (ce) begin
      seekStart_r <= 1'b0;
      xferGo <= 1'b0;
      rdata <= 8'h00;
      // A new event beats a clear in the same cycle
      irqSt_r <= (irqSt_r & ~irqClr) | irqSet;
      if (wr && (addr == `OFS_IRQ_MASK)) mask_r <= wdata[2:0];
      if (rd) begin
        if (addr == `OFS_MSR) rdata <= mainStatus;
        else if (addr == `OFS_IRQ_STAT) rdata <= {5'h00, irqSt_r};
        else if (addr == `OFS_IRQ_MASK) rdata <= {5'h00, mask_r};
      end
      case (state_r)
        ST_IDLE: begin
          if (wrData) begin
            opcode_r <= wdata;
            cmd_r <= newCmd;
            parIdx_r <= 2'd0;
            if (newCmd != `CMD_INVALID) standby <= 1'b0;
            state_r <= (newPars == 2'd0) ? ST_EXEC : ST_PARAM;
          end else if (xferStart) begin
            // Shared dump byte follows the last transfer kind
            shared_r <= xferIsFormat ? xferSc : xferEot; // R7 R8
            if (eis_r) begin
              seekUnit_r <= xferUnit; // R13
              seekTarget_r <= xferCyl;
              seekDirIn_r <= xferCyl > pcn_r[xferUnit];
              seekCount_r <= (xferCyl > pcn_r[xferUnit]) ?
                             xferCyl - pcn_r[xferUnit] :
                             pcn_r[xferUnit] - xferCyl;
              seekStart_r <= 1'b1;
              implied_r <= 1'b1;
              state_r <= ST_SEEK;
            end else begin
              xferGo <= 1'b1;
            end
          end
        end
        ST_PARAM: begin
          if (wrData) begin
            par_r[parIdx_r] <= wdata;
            parIdx_r <= parIdx_r + 2'd1;
            if (parIdx_r + 2'd1 == paramsOf(cmd_r)) state_r <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          // Unit selects are kept for internal use only
          headSide <= par_r[0][2]; // R9
          state_r <= ST_RESULT;
          resIdx_r <= 4'h0;
          resCnt_r <= 4'h1;
          case (cmd_r)
            `CMD_SENSE: resBuf_r[0] <= driveState; // R1
            `CMD_SEEK, `CMD_REL_SEEK: begin
              seekUnit_r <= unitSel;
              implied_r <= 1'b0;
              seekStart_r <= 1'b1;
              state_r <= ST_SEEK;
              if (cmd_r == `CMD_SEEK) begin
                seekTarget_r <= par_r[1]; // R2
                seekDirIn_r <= par_r[1] > curPcn;
                seekCount_r <= (par_r[1] > curPcn) ? par_r[1] - curPcn
                               : curPcn - par_r[1];
              end else begin
                seekTarget_r <= relTarget; // R11
                seekDirIn_r <= opcode_r[`BIT_DIR]; // R11
                seekCount_r <= par_r[1]; // R11
              end
            end
            `CMD_CONFIG: begin
              eis_r <= par_r[1][`BIT_EIS];
              bufOff_r <= par_r[1][`BIT_BUF_OFF];
              poll_r <= par_r[1][`BIT_POLL];
              thr_r <= par_r[1][3:0];
              precomp_start_cylinder_r <= par_r[2];
              state_r <= ST_IDLE;
            end
            `CMD_DUMP: begin
              for (k = 0; k < 4; k = k + 1) resBuf_r[k] <= pcn_r[k];
              resBuf_r[4] <= `RST_STEP_HUT;
              resBuf_r[5] <= `RST_HLT_ND;
              resBuf_r[6] <= shared_r; // R7 R8
              resBuf_r[7] <= {lock_r, 1'b0, perp_r};
              resBuf_r[8] <= {1'b0, eis_r, bufOff_r, poll_r, thr_r};
              resBuf_r[9] <= precomp_start_cylinder_r;
              resCnt_r <= 4'hA;
            end
            `CMD_READ_ID: begin
              mfmSel <= opcode_r[`BIT_MFM]; // R3
              state_r <= ST_IDWAIT;
            end
            `CMD_PERP: begin
              perp_r[1:0] <= par_r[0][1:0];
              // Drive bits change only with overwrite set
              if (par_r[0][`BIT_OVERWRITE]) perp_r[5:2] <= par_r[0][5:2];
              state_r <= ST_IDLE;
            end
            `CMD_LOCK: begin
              lock_r <= opcode_r[`BIT_LOCK]; // R12
              resBuf_r[0] <= {3'h0, opcode_r[`BIT_LOCK], 4'h0}; // R12
            end
            default: begin
              standby <= 1'b1; // R6
              resBuf_r[0] <= `RST_INVALID_ST0; // R6
            end
          endcase
        end
        ST_SEEK: begin
          if (stepDone) begin
            pcn_r[seekUnit_r] <= seekTarget_r; // R2
            xferGo <= implied_r; // R13
            state_r <= ST_IDLE;
          end
        end
        ST_IDWAIT: begin
          // First good ID ends the wait; no timeout here
          if (idFound) begin
            resBuf_r[0] <= {5'h00, par_r[0][2:0]}; // R4
            resBuf_r[1] <= 8'h00; // R4
            resBuf_r[2] <= 8'h00; // R4
            resBuf_r[3] <= idCyl; // R5
            resBuf_r[4] <= idHead; // R5
            resBuf_r[5] <= idSector; // R5
            resBuf_r[6] <= idSize; // R5
            resCnt_r <= 4'h7;
            resIdx_r <= 4'h0;
            state_r <= ST_RESULT;
          end
        end
        ST_RESULT: begin
          if (rdData) begin
            rdata <= resBuf_r[resIdx_r];
            resIdx_r <= resIdx_r + 4'h1;
            if (resIdx_r + 4'h1 == resCnt_r) state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

endmodule

// >>> bench/drive_model.sv
// Purpose: drive-side ID reader model for the aux decoder
// Assumes: idReadEn is a level while an ID is awaited
// Notes: ID lines churn every cycle, valid only with idFound
module drive_model #(
  parameter int DLY = 20
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic idReadEn,
  output logic idFound,
  output wire logic [7:0] idCyl,
  output wire logic [7:0] idHead,
  output wire logic [7:0] idSector,
  output wire logic [7:0] idSize
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pat;
  int cnt;
  // Changing pattern, so a stale capture cannot pass
  assign idCyl = pat;
  assign idHead = pat ^ 8'h3C;
  assign idSector = pat + 8'h11;
  assign idSize = {6'h00, pat[1:0]};
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pat <= 8'h5A;
      cnt <= 0;
      idFound <= 1'h0;
    end else begin
      pat <= pat + 8'h2B;
      idFound <= 1'h0;
      if (idReadEn && !idFound) begin
        cnt <= cnt + 1;
      end
      // One good ID per wait, after a slow search
      if (cnt == DLY) begin
        idFound <= 1'h1;
        cnt <= 0;
      end
    end
  end
endmodule

// >>> bench/fac_chk.sv
// Purpose: port-level assertions of the aux command decoder
// Assumes: one clock domain, nrst asynchronous active low
// Notes: sees ports only; phase is inferred from xferReady
module fac_chk (
  input wire core_clk,
  input wire nrst,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  input wire irq,
  input wire idFound,
  input wire idReadEn,
  input wire stepPulse,
  input wire stepDir,
  input wire standby,
  input wire xferReady,
  input wire xferGo
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////
  property p_rdIdle; !rd |=> rdata == 8'h00; endproperty
  a_rdIdle: assert property (p_rdIdle)
    else $error("rdata nonzero without a read");
  property p_stepGap; stepPulse |=> !stepPulse [*8]; endproperty
  a_stepGap: assert property (p_stepGap)
    else $error("step pulses too close");
  property p_stepBusy; stepPulse |-> !xferReady; endproperty
  a_stepBusy: assert property (p_stepBusy)
    else $error("step while idle");
  property p_stepDir; stepPulse |-> $stable(stepDir); endproperty
  a_stepDir: assert property (p_stepDir)
    else $error("direction moved at a step");
  property p_idBusy; idReadEn |-> !xferReady; endproperty
  a_idBusy: assert property (p_idBusy)
    else $error("ID wait while idle");
  property p_idDone; idReadEn && idFound |=> ##[0:3] !idReadEn; endproperty
  a_idDone: assert property (p_idDone)
    else $error("ID wait kept after a good ID");
  property p_goOne; xferGo |=> !xferGo; endproperty
  a_goOne: assert property (p_goOne)
    else $error("xferGo longer than one cycle");
  property p_standby; $rose(standby) |-> !xferReady; endproperty
  a_standby: assert property (p_standby)
    else $error("standby rose outside a command");
  property p_irqFall; $fell(irq) |-> $past(wr); endproperty
  a_irqFall: assert property (p_irqFall)
    else $error("irq fell without a write");
endmodule
bind floppy_aux_command_decoder fac_chk u_chk (.core_clk, .nrst, .wr,
  .rd, .rdata, .irq, .idFound, .idReadEn, .stepPulse, .stepDir,
  .standby, .xferReady, .xferGo);

// >>> bench/floppy_aux_command_decoder_tb.sv
// Purpose: self-checking bench of the aux command decoder
// Assumes: drive_model answers ID reads; ce dropped once
// Notes: read results are checked through an expectation queue
module floppy_aux_command_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'h0, nrst = 1'h0, wr = 1'h0, rd = 1'h0, rdQ = 1'h0;
  logic xferStart = 1'h0, xferIsFormat = 1'h0, ce = 1'h1;
  logic writeProtPin = 1'h0, readyPin = 1'h0, track0Pin = 1'h0;
  logic [1:0] addr = 2'h0, xferUnit = 2'h0;
  logic [7:0] wdata = 8'h00, xferCyl = 8'h00, xferSc = 8'h00;
  logic [7:0] xferEot = 8'h00, hs, pt;
  logic [31:0] idCap = 32'h0, rnd;
  logic [15:0] expQ[$];
  wire [7:0] rdata, idCyl, idHead, idSector, idSize;
  wire irq, idFound, idReadEn, mfmSel, headSide, stepPulse, stepDir;
  wire standby, xferReady, xferGo;
  int errors = 0, checkCount = 0, cyc = 0, steps = 0, seed = 63;
  floppy_aux_command_decoder u_dut (.core_clk, .nrst, .ce,
    .addr, .wdata, .wr, .rd, .rdata, .irq, .writeProtPin, .readyPin,
    .track0Pin, .idFound, .idCyl, .idHead, .idSector, .idSize,
    .idReadEn, .mfmSel, .headSide, .stepPulse, .stepDir, .standby,
    .xferStart, .xferIsFormat, .xferUnit, .xferCyl, .xferSc, .xferEot,
    .xferReady, .xferGo);
  drive_model u_drv (.core_clk, .nrst, .idReadEn, .idFound, .idCyl,
    .idHead, .idSector, .idSize);
  always #4 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("errors %0d checks %0d", errors, checkCount);
    if (errors == 0 && checkCount > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input [7:0] e, input [7:0] g);
    checkCount++;
    if (e !== g) begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wrB(input [1:0] a, input [7:0] d);
    @(posedge core_clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    wr <= 1'h0;
  endtask
  task automatic rdB(input [1:0] a, input [7:0] e, input [7:0] m);
    @(posedge core_clk);
    expQ.push_back({m, e});
    rd <= 1'h1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'h0;
  endtask
  task automatic cmd(input [7:0] op, input int n, input [23:0] p);
    wrB(2'h0, op);
    for (int i = 0; i < n; i++) wrB(2'h0, p[23-8*i -: 8]);
  endtask
  task automatic res(input int n, input [79:0] r);
    for (int i = n - 1; i >= 0; i--) rdB(2'h0, r[8*i +: 8], 8'hFF);
  endtask
  // Bounded waits: a stuck decoder shows up as a mismatch
  task automatic waitIrq;
    int n;
    n = 0;
    while (irq !== 1'h1 && n < 4000) begin
      @(posedge core_clk);
      n++;
    end
    chk("irq", 8'h01, {7'h00, irq});
    wrB(2'h2, 8'h07);
  endtask
  task automatic waitIdle;
    int n;
    n = 0;
    @(posedge core_clk);
    while (xferReady !== 1'h1 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    chk("idle", 8'h01, {7'h00, xferReady});
  endtask
  task automatic seekRun(input [7:0] op, c, n, input d);
    steps = 0;
    cmd(op, 2, {8'h01, c, 8'h00});
    rdB(2'h1, 8'h12, 8'h1F);
    waitIrq;
    chk("steps", n, steps[7:0]);
    chk("stepDir", {7'h00, d}, {7'h00, stepDir});
  endtask
  task automatic xfer(input f, input [7:0] n);
    int k;
    k = 0;
    steps = 0;
    @(posedge core_clk);
    xferStart <= 1'h1;
    xferIsFormat <= f;
    xferCyl <= 8'h02;
    @(posedge core_clk);
    xferStart <= 1'h0;
    while (xferGo !== 1'h1 && k < 4000) begin
      @(posedge core_clk);
      k++;
    end
    chk("xferGo", 8'h01, {7'h00, xferGo});
    chk("steps", n, steps[7:0]);
  endtask
  task automatic dump(input [7:0] sh, lk);
    cmd(8'h0E, 0, 24'h0);
    waitIrq;
    res(10, {16'h0202, 16'h0000, 16'hF002, sh, lk, 8'h45, pt});
  endtask
  ////////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    logic [15:0] ent;
    if (rdQ) begin
      ent = expQ.pop_front();
      chk("rdata", ent[7:0], rdata & ent[15:8]);
    end
    rdQ <= rd;
    if (idFound === 1'h1) idCap <= {idCyl, idHead, idSector, idSize};
  end
  always @(posedge core_clk) begin
    cyc++;
    if (stepPulse === 1'h1) steps++;
    if (cyc == 40000) begin
      errors++;
      stop_test;
    end
  end
  ////////////////////////////////////////////////////////////////////
  initial begin
    rnd = $random(seed);
    {writeProtPin, readyPin, track0Pin} <= rnd[2:0];
    hs = {5'h00, rnd[6:4]};
    pt = rnd[15:8];
    xferSc <= rnd[23:16];
    xferEot <= rnd[31:24];
    repeat (2) @(posedge core_clk);
    nrst <= 1'h1;
    @(posedge core_clk);
    chk("reset", 8'h80, {xferReady, standby, irq, xferGo, idReadEn,
      stepPulse, mfmSel, headSide});
    chk("resetRd", 8'h00, rdata);
    cmd(8'h04, 1, {hs, 16'h0});
    repeat (4) @(posedge core_clk);
    chk("irqMasked", 8'h00, {7'h00, irq});
    wrB(2'h3, 8'h07);
    @(posedge core_clk);
    chk("irqUnmasked", 8'h01, {7'h00, irq});
    // A clear written while ce is low must be lost
    ce <= 1'h0;
    wrB(2'h2, 8'h07);
    ce <= 1'h1;
    chk("ceHold", 8'h01, {7'h00, irq});
    rdB(2'h2, 8'h02, 8'hFF);
    wrB(2'h2, 8'h07);
    rdB(2'h0, {1'h0, rnd[2:0], 1'h1, hs[2:0]}, 8'hFF);
    chk("headSide", {7'h00, hs[2]}, {7'h00, headSide});
    rdB(2'h0, 8'h00, 8'hFF);
    seekRun(8'h0F, 8'h03, 8'h03, 1'h1);
    seekRun(8'h8F, 8'h02, 8'h02, 1'h0);
    seekRun(8'hCF, 8'h01, 8'h01, 1'h1);
    cmd(8'h13, 3, {8'h00, 8'h45, pt});
    waitIdle;
    xfer(1'h1, 8'h02);
    dump(xferSc, 8'h00);
    cmd(8'h12, 1, {8'hBD, 16'h0});
    waitIdle;
    cmd(8'h94, 0, 24'h0);
    waitIrq;
    res(1, 80'h10);
    xfer(1'h0, 8'h00);
    dump(xferEot, 8'hBD);
    for (int i = 0; i < 2; i++) begin
      cmd(i ? 8'h4A : 8'h0A, 1, {8'h05, 16'h0});
      waitIrq;
      res(7, {24'h050000, idCap});
      chk("mfmSel", i, {7'h00, mfmSel});
    end
    for (int i = 0; i < 3; i++) begin
      cmd(i == 0 ? 8'h00 : (i == 1 ? 8'hFF : 8'h1F), 0, 24'h0);
      rdB(2'h2, 8'h06, 8'hFF);
      waitIrq;
      chk("standby", 8'h01, {7'h00, standby});
      res(1, 80'h80);
    end
    cmd(8'h14, 0, 24'h0);
    waitIrq;
    res(1, 80'h00);
    chk("standby", 8'h00, {7'h00, standby});
    repeat (4) @(posedge core_clk);
    stop_test;
  end
endmodule
